// *** src/disk_dma_consts.vh ***
// Purpose: Shared constants for the disk DMA port handshake block
// Assumes: 40 MHz system clock
// Notes:   Times are in nanoseconds; cycle counts are derived from them
`ifndef DISK_DMA_CONSTS_VH
`define DISK_DMA_CONSTS_VH

`define CLK_PERIOD_NS       25
`define ACK_MAX_NS          250
// Longest time rounds down to whole cycles
`define ACK_MAX_CYC         (`ACK_MAX_NS / `CLK_PERIOD_NS)
`define ACK_PULSE_NS        100
`define ACK_PULSE_CYC       ((`ACK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_NS            50
`define SETUP_CYC           ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_LEN             6
`define CNT_W               4

`endif

// *** src/pulse_timer.v ***
// Purpose: Small down counter that flags when a loaded count has expired
// Assumes: Synchronous active-high reset
// Notes:   Load wins over counting
`timescale 1ns/1ps
`include "disk_dma_consts.vh"

module pulse_timer (
    input  wire               clk,
    input  wire               srst,
    input  wire               load,
    input  wire [`CNT_W-1:0]  value,
    output wire               done
);
    reg [`CNT_W-1:0] count;

    always @(posedge clk) begin
        if (srst) begin
            count <= 4'h0;
        end else if (load) begin
            count <= value;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign done = (count == 4'h0) && !load;
endmodule

// *** src/disk_dma_port_handshake.v ***
// Purpose: Host-side DMA port handshake toward an off-board disk controller
// Assumes: Port inputs synchronous to clk; memory side uses valid/ready
// Notes:   Command bytes go out first, then payload moves one byte per request
// Contract
// - Writing to the external controller drives port select low and address bit 1 high.
// - Acknowledge goes low no later than 250 ns after data request rises.
// - Low acknowledge means outbound data is valid, or inbound data has been taken.
// - The port sustains up to one megabyte per second.
// - Commands go out as a six-byte parameter block, then payload moves by DMA.
// - Outbound bytes come from the memory controller, inbound bytes go to it.
`timescale 1ns/1ps
`include "disk_dma_consts.vh"

module disk_dma_port_handshake (
    input  wire        clk,
    input  wire        srst,
    // Host command side
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_byte,
    input  wire        cmd_first,
    output reg         cmd_ready,
    input  wire        xfer_start,
    input  wire        xfer_read,
    input  wire [15:0] xfer_len,
    output reg         busy,
    output reg         done,
    // Memory controller side
    input  wire        mem_out_valid,
    input  wire [7:0]  mem_out_data,
    output reg         mem_out_ready,
    output reg         mem_in_valid,
    output reg  [7:0]  mem_in_data,
    input  wire        mem_in_ready,
    // Disk port
    input  wire [7:0]  port_data_in,
    output reg  [7:0]  port_data_out,
    output reg         port_data_oe_n,
    output reg         disk_port_select_n,
    output reg         port_addr_bit1,
    output reg         port_read_write,
    output reg         port_ack_n,
    input  wire        disk_data_request,
    input  wire        disk_irq,
    output reg         host_irq
);
    // ************************************************
    // States
    // ************************************************
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_CSET  = 3'h1;
    localparam [2:0] ST_CSEL  = 3'h2;
    localparam [2:0] ST_WREQ  = 3'h3;
    localparam [2:0] ST_FETCH = 3'h4;
    localparam [2:0] ST_ACK   = 3'h5;
    localparam [2:0] ST_DROP  = 3'h6;
    localparam [2:0] ST_STORE = 3'h7;

    // ************************************************
    // Timer loads
    // ************************************************
    // Counts are cut to the timer width once here, so every load is exact
    localparam integer          SETUP_I   = `SETUP_CYC;
    localparam integer          PULSE_I   = `ACK_PULSE_CYC;
    localparam [`CNT_W-1:0]     SETUP_CNT = SETUP_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0]     PULSE_CNT = PULSE_I[`CNT_W-1:0];

    reg [2:0]  state;
    reg        phase_data;
    reg        dir_read;
    reg [15:0] remain;
    reg [7:0]  cmd_hold;
    reg        req_prev;
    reg        tmr_load;
    reg [`CNT_W-1:0] tmr_val;
    wire       tmr_done;

    pulse_timer u_timer (
        .clk   (clk),
        .srst  (srst),
        .load  (tmr_load),
        .value (tmr_val),
        .done  (tmr_done)
    );

    // Worst path from request seen to ack low is a few cycles, well under the limit
    wire req_rise = disk_data_request && !req_prev;

    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            phase_data <= 1'b0;
            dir_read <= 1'b0;
            remain <= 16'h0000;
            cmd_hold <= 8'h00;
            req_prev <= 1'b0;
            tmr_load <= 1'b0;
            tmr_val <= 4'h0;
            cmd_ready <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            mem_out_ready <= 1'b0;
            mem_in_valid <= 1'b0;
            mem_in_data <= 8'h00;
            port_data_out <= 8'h00;
            port_data_oe_n <= 1'b1;
            disk_port_select_n <= 1'b1;
            port_addr_bit1 <= 1'b0;
            port_read_write <= 1'b1;
            port_ack_n <= 1'b1;
            host_irq <= 1'b0;
        end else begin
            req_prev <= disk_data_request;
            host_irq <= disk_irq;
            tmr_load <= 1'b0;
            done <= 1'b0;
            cmd_ready <= 1'b0;
            mem_out_ready <= 1'b0;
            if (mem_in_valid && mem_in_ready) begin
                mem_in_valid <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    busy <= 1'b0;
                    if (cmd_valid && !cmd_ready) begin
                        // Write direction settles before select falls
                        cmd_hold <= cmd_byte;
                        port_read_write <= 1'b0;
                        port_addr_bit1 <= !cmd_first;
                        port_data_out <= cmd_byte;
                        port_data_oe_n <= 1'b0;
                        cmd_ready <= 1'b1;
                        busy <= 1'b1;
                        tmr_load <= 1'b1;
                        tmr_val <= SETUP_CNT;
                        state <= ST_CSET;
                    end else if (xfer_start && xfer_len != 16'h0000) begin
                        dir_read <= xfer_read;
                        remain <= xfer_len;
                        port_read_write <= xfer_read;
                        port_data_oe_n <= xfer_read;
                        phase_data <= 1'b1;
                        busy <= 1'b1;
                        state <= ST_WREQ;
                    end
                end
                ST_CSET: begin
                    if (tmr_done && !tmr_load) begin
                        disk_port_select_n <= 1'b0;
                        port_addr_bit1 <= 1'b1;
                        tmr_load <= 1'b1;
                        tmr_val <= PULSE_CNT;
                        state <= ST_CSEL;
                    end
                end
                ST_CSEL: begin
                    if (tmr_done && !tmr_load) begin
                        disk_port_select_n <= 1'b1;
                        port_read_write <= 1'b1;
                        port_data_oe_n <= 1'b1;
                        port_addr_bit1 <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_WREQ: begin
                    // Controller paces each byte
                    if (req_rise || disk_data_request) begin
                        if (dir_read) begin
                            mem_in_data <= port_data_in;
                            port_ack_n <= 1'b0;
                            tmr_load <= 1'b1;
                            tmr_val <= PULSE_CNT;
                            state <= ST_STORE;
                        end else begin
                            mem_out_ready <= 1'b1;
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    // Memory must answer within the ack limit
                    if (mem_out_valid && mem_out_ready) begin
                        port_data_out <= mem_out_data;
                        port_ack_n <= 1'b0;
                        tmr_load <= 1'b1;
                        tmr_val <= PULSE_CNT;
                        state <= ST_ACK;
                    end else begin
                        mem_out_ready <= 1'b1;
                    end
                end
                ST_STORE: begin
                    if (!mem_in_valid || mem_in_ready) begin
                        mem_in_valid <= 1'b1;
                        state <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (tmr_done && !tmr_load) begin
                        port_ack_n <= 1'b1;
                        state <= ST_DROP;
                    end
                end
                ST_DROP: begin
                    // Wait for request low; full byte cycle stays well under 1 us
                    if (!disk_data_request) begin
                        if (remain == 16'h0001) begin
                            remain <= 16'h0000;
                            phase_data <= 1'b0;
                            port_read_write <= 1'b1;
                            port_data_oe_n <= 1'b1;
                            done <= 1'b1;
                            state <= ST_IDLE;
                        end else begin
                            remain <= remain - 16'h0001;
                            state <= ST_WREQ;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// *** verification/disk_dma_sva.sv ***
// Purpose: Port-level checks for the disk DMA port handshake
// Assumes: One clock domain, srst synchronous active high
// Notes:   Ack bound is 10 cycles of 25 ns
`timescale 1ns/1ps

module disk_dma_sva (
    input wire       clk,
    input wire       srst,
    input wire       busy,
    input wire       cmd_valid,
    input wire       cmd_ready,
    input wire       xfer_read,
    input wire       disk_data_request,
    input wire       port_ack_n,
    input wire       disk_port_select_n,
    input wire       port_addr_bit1,
    input wire       port_read_write,
    input wire       port_data_oe_n,
    input wire [7:0] port_data_in,
    input wire [7:0] mem_in_data,
    input wire       mem_in_valid,
    input wire       disk_irq,
    input wire       host_irq,
    input wire       done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_sel_a1;
        !disk_port_select_n |-> port_addr_bit1 && !port_read_write;
    endproperty
    a_sel_a1: assert property (p_sel_a1) else $error("select without A1 high");
    property p_sel_len;
        // Timer load takes two extra edges, so the strobe stands six cycles
        $fell(disk_port_select_n) |-> !disk_port_select_n[*6] ##1 disk_port_select_n;
    endproperty
    a_sel_len: assert property (p_sel_len) else $error("select width wrong");
    property p_ack_fast;
        $rose(disk_data_request) && busy |-> ##[1:10] !port_ack_n;
    endproperty
    a_ack_fast: assert property (p_ack_fast) else $error("ack too late");
    property p_ack_len;
        $fell(port_ack_n) |-> !port_ack_n[*6] ##1 port_ack_n;
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack width wrong");
    property p_oe_out;
        $fell(port_ack_n) && !xfer_read |-> !port_data_oe_n;
    endproperty
    a_oe_out: assert property (p_oe_out) else $error("ack without data driven");
    property p_in_data;
        $fell(port_ack_n) && xfer_read |-> mem_in_data == $past(port_data_in) ##1 mem_in_valid;
    endproperty
    a_in_data: assert property (p_in_data) else $error("inbound byte lost");
    property p_cmd_take;
        cmd_valid && !busy |=> cmd_ready;
    endproperty
    a_cmd_take: assert property (p_cmd_take) else $error("command byte not taken");
    property p_rw_first;
        $fell(disk_port_select_n) |-> !$past(port_read_write);
    endproperty
    a_rw_first: assert property (p_rw_first) else $error("direction set late");
    property p_irq;
        1'b1 |=> host_irq == $past(disk_irq);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not forwarded");
    c_rd: cover property ($fell(port_ack_n) && xfer_read);
    c_wr: cover property ($fell(port_ack_n) && !xfer_read);
    c_done: cover property (done);
endmodule

bind disk_dma_port_handshake disk_dma_sva u_sva (.clk(clk), .srst(srst), .busy(busy),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .xfer_read(xfer_read),
    .disk_data_request(disk_data_request), .port_ack_n(port_ack_n),
    .disk_port_select_n(disk_port_select_n), .port_addr_bit1(port_addr_bit1),
    .port_read_write(port_read_write), .port_data_oe_n(port_data_oe_n),
    .port_data_in(port_data_in), .mem_in_data(mem_in_data), .mem_in_valid(mem_in_valid),
    .disk_irq(disk_irq), .host_irq(host_irq), .done(done));

// *** verification/disk_ctrl_model.sv ***
// Purpose: Behavioural off-board disk controller on the DMA port
// Assumes: gap sets how slowly each request follows the last
// Notes:   Released data lines show the inverse of the last byte
`timescale 1ns/1ps

module disk_ctrl_model (
    input  wire       clk,
    input  wire       en,
    input  wire [3:0] gap,
    input  wire       ack_n,
    input  wire       oe_n,
    input  wire [7:0] dout,
    output reg        req,
    output reg  [7:0] din,
    output reg  [7:0] got
);
    reg [7:0] seq;
    reg [3:0] w;
    initial begin
        req = 1'b0;
        din = 8'hA5;
        got = 8'h00;
        seq = 8'h10;
        w = 4'h0;
    end
    always @(posedge clk) begin
        if (req && !ack_n) begin
            req <= 1'b0;
            din <= ~din;
            seq <= seq + 8'h01;
            if (!oe_n)
                got <= dout;
        end else if (!req && ack_n && en) begin
            w <= (w >= gap) ? 4'h0 : w + 4'h1;
            if (w >= gap) begin
                req <= 1'b1;
                din <= seq;
            end
        end
    end
endmodule

// *** verification/disk_dma_port_handshake_bench.sv ***
// Purpose: Self-checking bench for the disk DMA port handshake
// Assumes: Inputs change at the falling edge
// Notes:   Read runs before write; read draws from the model's byte sequence, write from the bench's mem_out_data count
`timescale 1ns/1ps
`include "disk_dma_consts.vh"

module disk_dma_port_handshake_bench;
    reg clk = 0, srst = 1, cmd_valid = 0, cmd_first = 0, xfer_start = 0, xfer_read = 0;
    reg mem_out_valid = 0, mem_in_ready = 1, disk_irq = 0, en = 0, seen_sel = 0, took = 0;
    reg [7:0] cmd_byte = 8'h00, mem_out_data = 8'h50, sel_byte = 8'h00, exp_rx = 8'h10;
    reg [15:0] xfer_len = 16'h0000;
    reg [3:0] gap = 4'h0;
    integer err_total = 0, n_tests = 0, rx_n = 0;
    wire cmd_ready, busy, done, mem_out_ready, mem_in_valid, oe_n, sel_n, a1, rw, ack_n, req, irq;
    wire [7:0] mem_in_data, pdout, pdin, got;

    disk_dma_port_handshake DUT (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
        .cmd_byte(cmd_byte), .cmd_first(cmd_first), .cmd_ready(cmd_ready),
        .xfer_start(xfer_start), .xfer_read(xfer_read), .xfer_len(xfer_len), .busy(busy),
        .done(done), .mem_out_valid(mem_out_valid), .mem_out_data(mem_out_data),
        .mem_out_ready(mem_out_ready), .mem_in_valid(mem_in_valid), .mem_in_data(mem_in_data),
        .mem_in_ready(mem_in_ready), .port_data_in(pdin), .port_data_out(pdout),
        .port_data_oe_n(oe_n), .disk_port_select_n(sel_n), .port_addr_bit1(a1),
        .port_read_write(rw), .port_ack_n(ack_n), .disk_data_request(req),
        .disk_irq(disk_irq), .host_irq(irq));
    disk_ctrl_model u_far (.clk(clk), .en(en), .gap(gap), .ack_n(ack_n), .oe_n(oe_n),
        .dout(pdout), .req(req), .din(pdin), .got(got));

    task chk(input [15:0] g, input [15:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task give_verdict;
        begin
            $display("tests=%0d errors=%0d", n_tests, err_total);
            if (err_total == 0 && n_tests > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // Snapshot of the port while selected, and of memory-side traffic
    always @(posedge clk) begin
        // Cleared here on each accepted byte so only this process drives the flag
        if (cmd_ready) begin
            seen_sel <= 1'b0;
        end else if (!sel_n && a1) begin
            seen_sel <= 1'b1;
            sel_byte <= pdout;
        end
        took <= mem_out_valid && mem_out_ready;
        if (mem_in_valid && mem_in_ready) begin
            chk(mem_in_data, exp_rx);
            exp_rx <= exp_rx + 8'h01;
            rx_n <= rx_n + 1;
        end
    end
    always @(negedge clk)
        if (took)
            mem_out_data = mem_out_data + 8'h01;

    task send_cmd;
        integer i, k;
        begin
            for (i = 0; i < `CMD_LEN; i = i + 1) begin
                @(negedge clk);
                cmd_valid = 1;
                cmd_byte = 8'hC0 + i;
                cmd_first = (i == 0);
                k = 0;
                while (cmd_ready !== 1'b1 && k < 20) begin
                    @(negedge clk);
                    k = k + 1;
                end
                cmd_valid = 0;
                while (busy !== 1'b0 && k < 40) begin
                    @(negedge clk);
                    k = k + 1;
                end
                chk(k < 40, 1);
                chk({seen_sel, sel_byte}, {1'b1, cmd_byte});
            end
        end
    endtask
    task xfer(input rd, input [15:0] n, input [3:0] g);
        integer k;
        begin
            @(negedge clk);
            xfer_read = rd;
            xfer_len = n;
            xfer_start = 1;
            gap = g;
            en = 1;
            mem_out_valid = !rd;
            @(negedge clk);
            xfer_start = 0;
            k = 0;
            while (done !== 1'b1 && k < 400) begin
                @(negedge clk);
                k = k + 1;
            end
            en = 0;
            mem_out_valid = 0;
            chk(k < n * 40, 1);
        end
    endtask

    initial
        forever #12.5 clk = ~clk;
    initial begin
        repeat (12) @(negedge clk);
        srst = 0;
        send_cmd;
        xfer(1, 16'h0005, 4'h0);
        chk(rx_n, 5);
        xfer(0, 16'h0004, 4'h5);
        chk({got, mem_out_data}, {8'h53, 8'h54});
        disk_irq = 1;
        repeat (2) @(negedge clk);
        chk(irq, 1);
        disk_irq = 0;
        repeat (2) @(negedge clk);
        give_verdict;
    end
    initial begin
        #200000;
        err_total = err_total + 1;
        give_verdict;
    end
endmodule
